// ==== core/fltq_top.sv ====
// Fault latch qualifier: pin overvoltage, supply overvoltage and thermal sequencing
`timescale 1ns/10ps
`include "fltq_defs.svh"
// Summary of operation
// - Latched: hold supply at bias until release
// - Detect from power-limit pin 3 V comparator
// - Blank comparator 1 us after turn-off
// - Ignore comparator highs shorter than 600 ns
// - Latch after four successive validated events
// - Events from consecutive switching cycles' off time
// - Overtemperature in stable operation stops pulses
// - After cooling, discharge supply then restart
// - Overtemperature elsewhere pauses sequence, then resumes
// - Supply above 27.5 V for 20 us latches
// - Supply latch cleared only by mains removal
module fltq_top
  import fltq_pkg::*;
#(
  parameter int EVENT_COUNT = `FLTQ_EVENT_COUNT,
  parameter int SUPOV_CYC = `FLTQ_SUPOV_CYC
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // Analog comparator inputs
  input wire logic POWER_LIMIT_PIN_ABOVE_3V,
  input wire logic SUPPLY_ABOVE_27V5,
  input wire logic SUPPLY_BELOW_4V,
  input wire logic MAINS_PRESENT,
  input wire logic THERMAL_SHUTDOWN_HIGH,
  input wire logic THERMAL_SHUTDOWN_LOW,
  input wire logic SUPPLY_DISCHARGED,
  // Controller status
  input wire logic DRIVER_ON,
  input wire logic STABLE_OPERATION,
  // Outputs to analog and driver
  output logic GATE_ENABLE,
  output logic SUPPLY_BIAS_HOLD,
  output logic LINE_CAP_DISCHARGE,
  output logic SEQUENCE_PAUSE,
  output logic RESTART_REQ,
  output logic PIN_LATCHED,
  output logic SUPPLY_LATCHED
);
  // Two-flop synchronisers for every asynchronous input
  localparam int NSYNC = 9;
  wire [NSYNC-1:0] raw_in = {POWER_LIMIT_PIN_ABOVE_3V, SUPPLY_ABOVE_27V5, SUPPLY_BELOW_4V, MAINS_PRESENT,
                             THERMAL_SHUTDOWN_HIGH, THERMAL_SHUTDOWN_LOW, SUPPLY_DISCHARGED, DRIVER_ON,
                             STABLE_OPERATION};
  logic [NSYNC-1:0] sync1; // First stage, read only by second
  logic [NSYNC-1:0] sync2; // Safe copy

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      // Per-bit two-flop stage
      always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end else begin
          sync1[gi] <= raw_in[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  // Named views of synchronised inputs
  wire pin_cmp = sync2[8];
  wire sup_ov = sync2[7];
  wire sup_low = sync2[6];
  wire mains = sync2[5];
  wire hot = sync2[4];
  wire cool = sync2[3];
  wire discharged = sync2[2];
  wire drv_on = sync2[1];
  wire stable = sync2[0];

  // Turn-off edge framing of each switching cycle
  logic drv_q; // Previous driver state
  wire off_start = drv_q && !drv_on;
  wire on_start = !drv_q && drv_on; // Closes previous off time
  logic cycle_seen; // An off time has been observed
  logic cycle_hit; // That off time produced an event
  wire event_ok;

  fltq_pulse_qual u_qual (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .off_start(off_start),
    .in_off(!drv_on),
    .cmp(pin_cmp),
    .event_ok(event_ok)
  );

  // Successive-event counter
  logic [2:0] run_cnt;
  logic pin_latch; // Pin overvoltage latch state
  localparam logic [2:0] RUN_LAST = 3'(EVENT_COUNT);
  wire run_full = (run_cnt + 3'h1 >= RUN_LAST) && event_ok;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      drv_q <= 1'b0;
      cycle_seen <= 1'b0;
      cycle_hit <= 1'b0;
    end else begin
      drv_q <= drv_on;
      if (off_start) begin
        cycle_seen <= 1'b1;
        cycle_hit <= 1'b0;
      end else if (event_ok) begin
        cycle_hit <= 1'b1;
      end
    end
  end

  // Count only unbroken runs of event-bearing cycles
  // Latched state empties the count: after a release a fresh run of four is needed
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || pin_latch) begin
      run_cnt <= 3'h0;
    end else if (event_ok) begin
      run_cnt <= run_cnt + 3'h1;
    end else if (on_start && cycle_seen && !cycle_hit) begin
      run_cnt <= 3'h0;
    end
  end

  // Supply overvoltage duration counter: must exceed 20 us
  logic [15:0] sup_cnt;
  localparam logic [15:0] SUP_LAST = 16'(SUPOV_CYC);
  wire sup_trip = sup_ov && (sup_cnt + 16'h0001 >= SUP_LAST);

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || !sup_ov) begin
      sup_cnt <= 16'h0000;
    end else if (sup_cnt != 16'hffff) begin
      sup_cnt <= sup_cnt + 16'h0001;
    end
  end

  // Latches: pin latch releases on mains loss or forced low supply
  logic sup_latch;
  wire pin_release = !mains || sup_low;
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      pin_latch <= 1'b0;
      sup_latch <= 1'b0;
    end else begin
      if (run_full) begin
        pin_latch <= 1'b1;
      end else if (pin_release) begin
        pin_latch <= 1'b0;
      end
      // Only mains removal frees supply lockout; set wins over clear
      if (sup_trip) begin
        sup_latch <= 1'b1;
      end else if (!mains) begin
        sup_latch <= 1'b0;
      end
    end
  end

  // Thermal sequencer
  fltq_state_e state;
  fltq_state_e next_state;
  wire any_latch = pin_latch || sup_latch;

  always_comb begin
    next_state = state;
    case (state)
      FLTQ_RUN: begin
        if (hot && stable) begin
          next_state = FLTQ_HOT_STOP;
        end else if (hot) begin
          next_state = FLTQ_SEQ_PAUSE;
        end
      end
      FLTQ_SEQ_PAUSE: begin
        if (cool) begin
          next_state = FLTQ_RUN;
        end
      end
      FLTQ_HOT_STOP: begin
        if (cool) begin
          next_state = FLTQ_DISCHARGE;
        end
      end
      FLTQ_DISCHARGE: begin
        // Heat during discharge only pauses it
        if (!hot && discharged) begin
          next_state = FLTQ_RUN;
        end
      end
      default: begin
        next_state = FLTQ_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      state <= FLTQ_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Registered outputs; latch kills gate in the cycle after detection
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      GATE_ENABLE <= 1'b0;
      SUPPLY_BIAS_HOLD <= 1'b0;
      LINE_CAP_DISCHARGE <= 1'b0;
      SEQUENCE_PAUSE <= 1'b0;
      RESTART_REQ <= 1'b0;
      PIN_LATCHED <= 1'b0;
      SUPPLY_LATCHED <= 1'b0;
    end else begin
      GATE_ENABLE <= !any_latch && !run_full && !sup_trip && !hot && next_state == FLTQ_RUN;
      SUPPLY_BIAS_HOLD <= any_latch || run_full || sup_trip;
      LINE_CAP_DISCHARGE <= (state == FLTQ_DISCHARGE) && !hot;
      SEQUENCE_PAUSE <= (next_state == FLTQ_SEQ_PAUSE) || (state == FLTQ_DISCHARGE && hot);
      RESTART_REQ <= (state == FLTQ_DISCHARGE) && (next_state == FLTQ_RUN);
      PIN_LATCHED <= pin_latch || run_full;
      SUPPLY_LATCHED <= sup_latch || sup_trip;
    end
  end

  // Assertions
  a_latch_after_four: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    $rose(pin_latch) |-> $past(run_cnt) == 3'(EVENT_COUNT - 1))
    else $error("pin latch set without full run");
  a_latch_holds_bias: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    pin_latch |=> SUPPLY_BIAS_HOLD)
    else $error("bias not held while latched");
  a_gate_off_latched: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    sup_trip |=> !GATE_ENABLE)
    else $error("gate on after supply trip");
  a_sup_latch_sticky: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    sup_latch && mains |=> sup_latch)
    else $error("supply latch cleared with mains");
  a_sup_wait_width: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    $rose(sup_latch) |-> $past(sup_cnt) >= 16'(SUPOV_CYC - 1))
    else $error("supply latch too early");
  a_no_event_blank: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    off_start |=> !event_ok [*8])
    else $error("event inside blanking");
  a_miss_clears_run: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    on_start && cycle_seen && !cycle_hit && !event_ok |=> run_cnt == 3'h0)
    else $error("run not cleared");
  a_hot_stops_gate: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    hot |=> !GATE_ENABLE)
    else $error("gate on while hot");
  a_pause_resume: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    state == FLTQ_SEQ_PAUSE && cool |=> state == FLTQ_RUN)
    else $error("paused sequence did not resume");
  a_cool_discharge: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    state == FLTQ_HOT_STOP && cool |=> state == FLTQ_DISCHARGE)
    else $error("no discharge after cooling");
endmodule

// ==== shared/fltq_defs.svh ====
// Timing and count constants for the fault latch qualifier
`ifndef FLTQ_DEFS_SVH
`define FLTQ_DEFS_SVH
`define FLTQ_CLK_HZ 10000000
`define FLTQ_BLANK_NS 1000
`define FLTQ_BLANK_CYC ((`FLTQ_BLANK_NS * (`FLTQ_CLK_HZ / 1000000) + 999) / 1000)
`define FLTQ_MINPW_NS 600
`define FLTQ_MINPW_CYC ((`FLTQ_MINPW_NS * (`FLTQ_CLK_HZ / 1000000) + 999) / 1000)
`define FLTQ_SUPOV_US 20
`define FLTQ_SUPOV_CYC (`FLTQ_SUPOV_US * (`FLTQ_CLK_HZ / 1000000) + 1)
`define FLTQ_EVENT_COUNT 4
`endif

// ==== shared/fltq_pkg.sv ====
// Types for the fault latch qualifier
package fltq_pkg;
  typedef enum logic [2:0] {
    FLTQ_RUN = 3'b000,
    FLTQ_SEQ_PAUSE = 3'b001,
    FLTQ_HOT_STOP = 3'b010,
    FLTQ_DISCHARGE = 3'b011,
    FLTQ_LATCHED = 3'b100
  } fltq_state_e;
endpackage

// ==== core/fltq_pulse_qual.sv ====
// Off-time pulse qualifier: blanking plus minimum high width
`timescale 1ns/10ps
`include "fltq_defs.svh"
module fltq_pulse_qual #(
  parameter int BLANK_CYC = `FLTQ_BLANK_CYC,
  parameter int MINPW_CYC = `FLTQ_MINPW_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Cycle framing
  input wire logic off_start,
  input wire logic in_off,
  // Synchronised comparator
  input wire logic cmp,
  // Qualified event, one pulse per off time at most
  output logic event_ok
);
  localparam logic [7:0] BLANK_LAST = 8'(BLANK_CYC);
  localparam logic [7:0] MINPW_LAST = 8'(MINPW_CYC);
  logic [7:0] blank_cnt; // Blanking elapsed counter
  logic [7:0] high_cnt; // Comparator high-time counter
  logic done; // Event already given this off time
  wire blanked = in_off && (blank_cnt < BLANK_LAST); // Ringing window
  wire sampling = in_off && !blanked && cmp;
  wire width_met = sampling && (high_cnt + 8'h01 >= MINPW_LAST);

  // Blanking counter restarts at every turn-off
  always_ff @(posedge clk) begin
    if (rst || off_start) begin
      blank_cnt <= 8'h00;
    end else if (blanked) begin
      blank_cnt <= blank_cnt + 8'h01;
    end
  end

  // Width counter clears on any low sample: short pulses vanish
  always_ff @(posedge clk) begin
    if (rst || off_start || !sampling) begin
      high_cnt <= 8'h00;
    end else if (high_cnt != 8'hff) begin
      high_cnt <= high_cnt + 8'h01;
    end
  end

  // One event per off time, once width is met
  always_ff @(posedge clk) begin
    if (rst || off_start) begin
      done <= 1'b0;
      event_ok <= 1'b0;
    end else begin
      event_ok <= width_met && !done;
      if (width_met) begin
        done <= 1'b1;
      end
    end
  end
endmodule

// ==== test/fltq_sense_model.sv ====
// Far-side model: switching cycle framing and power-limit pin comparator
`timescale 1ns/10ps
module fltq_sense_model (
  // Clock
  input wire logic clk,
  // Pulse kind: 0 none, 1 long, 2 short, 3 inside blanking
  input wire logic [1:0] mode,
  // Comparator and driver state
  output logic driver_on,
  output logic pin_above
);
  int ph = 0; // Phase in a 40-cycle switching period
  int k; // Index inside the off time
  // Period counter, moved on the falling edge like all stimulus
  always @(negedge clk) begin
    ph <= (ph == 39) ? 0 : ph + 1;
  end
  assign driver_on = (ph < 10); // Ten on, thirty off
  assign k = ph - 10;
  // Pin above 3 V only inside the off time
  assign pin_above = (mode == 2'h1 && k >= 11 && k <= 20) || (mode == 2'h2 && k >= 11 && k <= 15) ||
                     (mode == 2'h3 && k >= 1 && k <= 8);
endmodule

// ==== test/fltq_top_tb.sv ====
// Self-checking testbench for the fault latch qualifier
`timescale 1ns/10ps
module fltq_top_tb;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] mode = 2'h0;
  logic drv_on, pin_hi;
  logic sup_hi = 1'b0, sup_lo = 1'b0, mains = 1'b1, hot = 1'b0, cool = 1'b1, dischd = 1'b0, stable = 1'b1;
  logic gate, bias, dis, pause, restart, pin_lat, sup_lat;
  int errors = 0;
  int num_checks = 0;
  // 10 MHz system clock
  always #50 clk_sys = ~clk_sys;
  fltq_sense_model u_model (.clk(clk_sys), .mode(mode), .driver_on(drv_on), .pin_above(pin_hi));
  // Short supply filter keeps the run brief
  fltq_top #(.SUPOV_CYC(5)) u_dut (
    .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .POWER_LIMIT_PIN_ABOVE_3V(pin_hi), .SUPPLY_ABOVE_27V5(sup_hi),
    .SUPPLY_BELOW_4V(sup_lo), .MAINS_PRESENT(mains), .THERMAL_SHUTDOWN_HIGH(hot), .THERMAL_SHUTDOWN_LOW(cool),
    .SUPPLY_DISCHARGED(dischd), .DRIVER_ON(drv_on), .STABLE_OPERATION(stable), .GATE_ENABLE(gate),
    .SUPPLY_BIAS_HOLD(bias), .LINE_CAP_DISCHARGE(dis), .SEQUENCE_PAUSE(pause), .RESTART_REQ(restart),
    .PIN_LATCHED(pin_lat), .SUPPLY_LATCHED(sup_lat));
  // Compare one bit, four-state exact
  task automatic chk(input logic seen, input logic exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Set pulse kind now, then run n periods; later calls land in on time
  task automatic sw(input logic [1:0] m, input int n);
    mode = m;
    repeat (n) @(negedge clk_sys iff u_model.ph == 5);
  endtask
  // Pin path: blanking, width, unbroken run, release
  task automatic t_pin();
    sw(2'h3, 4);
    chk(pin_lat, 1'b0);
    sw(2'h1, 3);
    sw(2'h2, 1);
    sw(2'h1, 3);
    chk(pin_lat, 1'b0);
    chk(gate, 1'b1);
    sw(2'h1, 1);
    chk(pin_lat, 1'b1);
    chk(gate, 1'b0);
    chk(bias, 1'b1);
    mode = 2'h0;
    sup_lo = 1'b1;
    tick(5);
    chk(pin_lat, 1'b0);
    sup_lo = 1'b0;
    tick(3);
    chk(gate, 1'b1);
  endtask
  // Supply overvoltage filter and mains-only release
  task automatic t_supply();
    sup_hi = 1'b1;
    tick(4);
    sup_hi = 1'b0;
    tick(4);
    chk(sup_lat, 1'b0);
    sup_hi = 1'b1;
    tick(10);
    sup_hi = 1'b0;
    chk(sup_lat, 1'b1);
    chk(gate, 1'b0);
    sup_lo = 1'b1;
    tick(5);
    chk(sup_lat, 1'b1);
    sup_lo = 1'b0;
    mains = 1'b0;
    tick(5);
    chk(sup_lat, 1'b0);
    mains = 1'b1;
    tick(3);
  endtask
  // Heat in stable operation: stop, discharge, restart
  task automatic t_hot_stable();
    int i;
    hot = 1'b1;
    cool = 1'b0;
    tick(4);
    chk(gate, 1'b0);
    hot = 1'b0;
    cool = 1'b1;
    tick(5);
    chk(dis, 1'b1);
    chk(gate, 1'b0);
    // Heat during discharge only pauses it
    hot = 1'b1;
    cool = 1'b0;
    tick(4);
    chk(pause, 1'b1);
    chk(dis, 1'b0);
    hot = 1'b0;
    cool = 1'b1;
    tick(4);
    chk(pause, 1'b0);
    chk(dis, 1'b1);
    dischd = 1'b1;
    for (i = 0; i < 8 && restart !== 1'b1; i++) tick(1);
    chk(restart, 1'b1);
    dischd = 1'b0;
    tick(3);
    chk(restart, 1'b0);
    chk(dis, 1'b0);
    chk(gate, 1'b1);
  endtask
  // Heat outside stable operation only pauses
  task automatic t_hot_pause();
    stable = 1'b0;
    hot = 1'b1;
    cool = 1'b0;
    tick(4);
    chk(pause, 1'b1);
    chk(dis, 1'b0);
    hot = 1'b0;
    cool = 1'b1;
    tick(4);
    chk(pause, 1'b0);
    chk(restart, 1'b0);
    stable = 1'b1;
    tick(3);
  endtask
  // Verdict and end of run
  task automatic complete_run();
    if (errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    tick(16);
    chk(gate, 1'b0);
    sys_rst = 1'b0;
    tick(4);
    chk(gate, 1'b1);
    t_pin();
    t_supply();
    t_hot_stable();
    t_hot_pause();
    complete_run();
  end
  // Watchdog well beyond the expected run length
  initial begin
    tick(20000);
    errors++;
    complete_run();
  end
endmodule
